// ---- verilog/xabd_decode_timing.v ----
// decode and cycle timing for adjust, add, logic, bound, scan, swap and bit-test ops
//
// What this block does
// RL1 - opcode 37 decodes as add adjust, 7 clocks any mode
// RL2 - opcode 3f decodes as subtract adjust, 7 clocks any mode
// RL3 - bytes d5 0a decode as divide adjust, 7 clocks
// RL4 - bytes d4 0a decode as multiply adjust, 13 to 21 clocks by data
// RL5 - add-with-carry in five forms incl. group 8x reg 010, 1 clock
// RL6 - add in five forms incl. group 8x reg 000, 1 clock
// RL7 - and in five forms, group reg 100, clears overflow and carry
// RL8 - opcode 63 privilege adjust, 9 clocks, protected mode only, sets zero
// RL9 - opcode 62 bound: 11 in range, 20 and vector 5 when out
// RL10 - 0f bc / 0f bd scans take 3 clocks and update zero
// RL11 - bit test: immediate 2 clocks, register form 5 or 6, carry gets bit
// RL12 - test-complement: immediate 3 clocks, register form 5 or 6
// RL13 - uncached memory adds 2 clocks at 2x, 4 clocks at 3x
// RL14 - two-register effective address adds one clock
// RL15 - 0f c8+r swaps the bytes of a register in 4 clocks, flags kept
`timescale 1ns/10ps
`include "xabd_consts.vh"
module xabd_decode_timing #(
  parameter CLK_RATIO3X = 0
) (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire [7:0] opByte0,
  input wire [7:0] opByte1,
  input wire [7:0] opByte2,
  input wire protMode,
  input wire memMiss,
  input wire twoRegEa,
  input wire boundOut,
  input wire [3:0] mulExtra,
  input wire [31:0] swapIn,
  output wire busy,
  output reg done,
  output reg [3:0] opClass,
  output reg [4:0] latency,
  output reg [5:0] flagWrMask,
  output reg [5:0] flagClrMask,
  output reg [5:0] flagUndefMask,
  output reg illegal,
  output reg raiseInt,
  output reg [7:0] intVector,
  output reg [2:0] regNum,
  output reg [31:0] swapOut
);
  // flag bit order: overflow, sign, zero, aux carry, parity, carry
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rstMeta_reg;
  reg rstSync_reg;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire rstn = rstSync_reg;
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire [2:0] b1Reg = opByte1[5:3];
  wire [2:0] b2Reg = opByte2[5:3];
  wire b1IsMem = (opByte1[7:6] != 2'b11);
  wire b2IsMem = (opByte2[7:6] != 2'b11);
  reg [3:0] cls;
  reg [4:0] base;
  reg usesMem;
  reg bad;
  reg [5:0] fw;
  reg [5:0] fc;
  reg [5:0] fu;
  always @* begin
    cls = `XABD_CLS_NONE;
    base = `XABD_LAT_ALU;
    usesMem = 1'b0;
    bad = 1'b0;
    fw = 6'h00;
    fc = 6'h00;
    fu = 6'h00;
    if (opByte0 == `XABD_OP_DAA_ADD || opByte0 == `XABD_OP_DAA_SUB) begin
      cls = `XABD_CLS_ADJ; // see RL1 see RL2
      base = `XABD_LAT_ADJ;
      fw = 6'h05;
      fu = 6'h3a;
    end else if (opByte0 == `XABD_OP_DIV_ADJ && opByte1 == `XABD_OP_BASE10) begin
      cls = `XABD_CLS_ADJ; // see RL3
      base = `XABD_LAT_ADJ;
      fw = 6'h1a;
      fu = 6'h25;
    end else if (opByte0 == `XABD_OP_MUL_ADJ && opByte1 == `XABD_OP_BASE10) begin
      cls = `XABD_CLS_MULADJ; // see RL4
      base = (mulExtra > 4'h8) ? `XABD_LAT_MULMAX : (`XABD_LAT_MULMIN + {1'b0, mulExtra});
      fw = 6'h1a;
      fu = 6'h25;
    end else if (opByte0[7:6] == 2'b00 && opByte0[5:4] != 2'b11 && opByte0[3] == 1'b0) begin
      // rows 0x, 1x, 2x: only xx0-xx5 taken, xx6/xx7 belong to other ops
      if (opByte0[2:1] == 2'b11) begin
        bad = 1'b1;
      end else begin
        cls = (opByte0[5:4] == 2'h0) ? `XABD_CLS_ADD : // see RL6
              (opByte0[5:4] == 2'h1) ? `XABD_CLS_ADC : `XABD_CLS_AND; // see RL5 see RL7
        // accumulator forms carry an immediate, not an address byte
        usesMem = b1IsMem && !opByte0[2];
      end
    end else if (opByte0[7:2] == `XABD_OP_GRP8) begin
      usesMem = b1IsMem;
      if (b1Reg == `XABD_REG_ADD) cls = `XABD_CLS_ADD; // see RL6
      else if (b1Reg == `XABD_REG_ADC) cls = `XABD_CLS_ADC; // see RL5
      else if (b1Reg == `XABD_REG_AND) cls = `XABD_CLS_AND; // see RL7
      else bad = 1'b1;
    end else if (opByte0 == `XABD_OP_PRIV) begin
      cls = `XABD_CLS_PRIV; // see RL8
      base = `XABD_LAT_PRIV;
      usesMem = b1IsMem;
      fw = 6'h08;
      bad = !protMode;
    end else if (opByte0 == `XABD_OP_BOUND) begin
      cls = `XABD_CLS_BOUND; // see RL9
      base = boundOut ? `XABD_LAT_BNDOUT : `XABD_LAT_BNDIN;
      usesMem = 1'b1;
    end else if (opByte0 == `XABD_OP_ESC) begin
      if (opByte1 == `XABD_OP_SCANF || opByte1 == `XABD_OP_SCANR) begin
        cls = `XABD_CLS_SCAN; // see RL10
        base = `XABD_LAT_SCAN;
        usesMem = b2IsMem;
        fw = 6'h08;
      end else if (opByte1[7:3] == `XABD_OP_SWAPHI) begin
        cls = `XABD_CLS_SWAP; // see RL15
        base = `XABD_LAT_SWAP;
      end else if (opByte1 == `XABD_OP_BTGRP && b2Reg == `XABD_REG_BT) begin
        cls = `XABD_CLS_BT; // see RL11
        base = `XABD_LAT_BTI;
        usesMem = b2IsMem;
        fw = 6'h01;
      end else if (opByte1 == `XABD_OP_BTGRP && b2Reg == `XABD_REG_BTC) begin
        cls = `XABD_CLS_BTC; // see RL12
        base = `XABD_LAT_BTCI;
        usesMem = b2IsMem;
        fw = 6'h01;
      end else if (opByte1 == `XABD_OP_BTREG || opByte1 == `XABD_OP_BTCREG) begin
        cls = (opByte1 == `XABD_OP_BTREG) ? `XABD_CLS_BT : `XABD_CLS_BTC; // see RL11 see RL12
        base = b2IsMem ? `XABD_LAT_BTRM : `XABD_LAT_BTRR;
        usesMem = b2IsMem;
        fw = 6'h01;
      end else begin
        bad = 1'b1;
      end
    end else begin
      bad = 1'b1;
    end
    if (cls == `XABD_CLS_ADD || cls == `XABD_CLS_ADC) begin
      fw = 6'h3f;
    end else if (cls == `XABD_CLS_AND) begin
      fw = 6'h1a; // see RL7
      fc = 6'h21;
      fu = 6'h04;
    end
    if (bad) begin
      cls = `XABD_CLS_NONE;
      fw = 6'h00;
      fc = 6'h00;
      fu = 6'h00;
    end
  end
  // extra cycles: a miss or a two-register address adds to the listed time
  wire [4:0] missAdd = (CLK_RATIO3X != 0) ? `XABD_ADD_MISS3X : `XABD_ADD_MISS2X;
  wire [4:0] addMiss = (usesMem && memMiss) ? missAdd : 5'h00; // see RL13
  wire [4:0] addEa = (usesMem && twoRegEa) ? `XABD_ADD_TWOREG : 5'h00; // see RL14
  wire [4:0] total = base + addMiss + addEa;
  // ------------------------------------------------------------
  // execution timer
  // ------------------------------------------------------------
  reg [4:0] count_reg;
  reg running_reg;
  assign busy = running_reg;
  wire accept = start && !running_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 5'h00;
      running_reg <= 1'b0;
      done <= 1'b0;
      opClass <= `XABD_CLS_NONE;
      latency <= 5'h00;
      flagWrMask <= 6'h00;
      flagClrMask <= 6'h00;
      flagUndefMask <= 6'h00;
      illegal <= 1'b0;
      raiseInt <= 1'b0;
      intVector <= 8'h00;
      regNum <= 3'h0;
      swapOut <= 32'h00000000;
    end else begin
      done <= 1'b0;
      raiseInt <= 1'b0;
      if (accept) begin
        opClass <= cls;
        latency <= bad ? 5'h01 : total;
        flagWrMask <= fw;
        flagClrMask <= fc;
        flagUndefMask <= fu;
        illegal <= bad;
        regNum <= opByte1[2:0];
        if (cls == `XABD_CLS_SWAP) begin
          swapOut <= {swapIn[7:0], swapIn[15:8], swapIn[23:16], swapIn[31:24]}; // see RL15
        end
        intVector <= (cls == `XABD_CLS_BOUND && boundOut) ? `XABD_VEC_BOUND : 8'h00;
        count_reg <= (bad ? 5'h01 : total) - 5'h01;
        if (bad || total == 5'h01) begin
          done <= 1'b1;
          raiseInt <= 1'b0;
        end else begin
          running_reg <= 1'b1;
        end
      end else if (running_reg) begin
        count_reg <= count_reg - 5'h01;
        if (count_reg == 5'h01) begin
          running_reg <= 1'b0;
          done <= 1'b1;
          raiseInt <= (intVector == `XABD_VEC_BOUND); // see RL9
        end
      end
    end
  end
endmodule

// ---- verilog/xabd_consts.vh ----
// constants for the arithmetic/bit-op decode and timing block
`ifndef XABD_CONSTS_VH
`define XABD_CONSTS_VH
`define XABD_OP_DAA_ADD 8'h37
`define XABD_OP_DAA_SUB 8'h3f
`define XABD_OP_DIV_ADJ 8'hd5
`define XABD_OP_MUL_ADJ 8'hd4
`define XABD_OP_BASE10 8'h0a
`define XABD_OP_PRIV 8'h63
`define XABD_OP_BOUND 8'h62
`define XABD_OP_ESC 8'h0f
`define XABD_OP_SCANF 8'hbc
`define XABD_OP_SCANR 8'hbd
`define XABD_OP_BTGRP 8'hba
`define XABD_OP_BTREG 8'ha3
`define XABD_OP_BTCREG 8'hbb
`define XABD_OP_SWAPHI 5'h19
`define XABD_OP_GRP8 6'h20
`define XABD_REG_ADC 3'h2
`define XABD_REG_ADD 3'h0
`define XABD_REG_AND 3'h4
`define XABD_REG_BT 3'h4
`define XABD_REG_BTC 3'h7
`define XABD_LAT_ADJ 5'h07
`define XABD_LAT_MULMIN 5'h0d
`define XABD_LAT_MULMAX 5'h15
`define XABD_LAT_ALU 5'h01
`define XABD_LAT_PRIV 5'h09
`define XABD_LAT_BNDIN 5'h0b
`define XABD_LAT_BNDOUT 5'h14
`define XABD_LAT_SCAN 5'h03
`define XABD_LAT_SWAP 5'h04
`define XABD_LAT_BTI 5'h02
`define XABD_LAT_BTCI 5'h03
`define XABD_LAT_BTRR 5'h05
`define XABD_LAT_BTRM 5'h06
`define XABD_ADD_MISS2X 5'h02
`define XABD_ADD_MISS3X 5'h04
`define XABD_ADD_TWOREG 5'h01
`define XABD_VEC_BOUND 8'h05
`define XABD_CLS_NONE 4'h0
`define XABD_CLS_ADJ 4'h1
`define XABD_CLS_MULADJ 4'h2
`define XABD_CLS_ADC 4'h3
`define XABD_CLS_ADD 4'h4
`define XABD_CLS_AND 4'h5
`define XABD_CLS_PRIV 4'h6
`define XABD_CLS_BOUND 4'h7
`define XABD_CLS_SCAN 4'h8
`define XABD_CLS_SWAP 4'h9
`define XABD_CLS_BT 4'ha
`define XABD_CLS_BTC 4'hb
`endif

// ---- testbench/xabd_decode_timing_props.sv ----
// checker: port-level decode and timing properties
`timescale 1ns/10ps
module xabd_decode_timing_props #(
  parameter CLK_RATIO3X = 0
) (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire busy,
  input wire done,
  input wire [7:0] opByte0,
  input wire [7:0] opByte1,
  input wire protMode,
  input wire memMiss,
  input wire twoRegEa,
  input wire boundOut,
  input wire [3:0] mulExtra,
  input wire [31:0] swapIn,
  input wire [3:0] opClass,
  input wire [4:0] latency,
  input wire [5:0] flagWrMask,
  input wire [5:0] flagClrMask,
  input wire [5:0] flagUndefMask,
  input wire raiseInt,
  input wire [7:0] intVector,
  input wire [31:0] swapOut
);
  // ----
  // properties
  // ----
  // memory extras are excluded where a fixed figure is expected
  wire acc = start && !busy;
  wire hit = acc && !memMiss && !twoRegEa;
  wire [31:0] swapExp = {swapIn[7:0], swapIn[15:8], swapIn[23:16], swapIn[31:24]};
  wire [4:0] missLat = CLK_RATIO3X ? 5'h05 : 5'h03;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_add_adj; acc && opByte0 == 8'h37 |=> busy [*6] ##1 done; endproperty
  a_add_adj: assert property (p_add_adj) else $error("add adjust timing");
  property p_sub_adj; acc && opByte0 == 8'h3f |=> opClass == 4'h1 && latency == 5'h07; endproperty
  a_sub_adj: assert property (p_sub_adj) else $error("sub adjust decode");
  property p_mul_adj;
    acc && opByte0 == 8'hd4 && opByte1 == 8'h0a |=>
      latency == ($past(mulExtra) > 4'h8 ? 5'h15 : 5'h0d + {1'b0, $past(mulExtra)});
  endproperty
  a_mul_adj: assert property (p_mul_adj) else $error("mul adjust latency");
  property p_and; hit && opByte0 == 8'h20 |=> done && flagClrMask == 6'h21 && flagUndefMask == 6'h04; endproperty
  a_and: assert property (p_and) else $error("and flags");
  property p_priv; hit && protMode && opByte0 == 8'h63 |=> latency == 5'h09 && flagWrMask == 6'h08; endproperty
  a_priv: assert property (p_priv) else $error("privilege adjust");
  property p_bound; hit && opByte0 == 8'h62 && boundOut |=> intVector == 8'h05 ##19 done && raiseInt; endproperty
  a_bound: assert property (p_bound) else $error("bound out timing");
  property p_int; raiseInt |-> done && intVector == 8'h05; endproperty
  a_int: assert property (p_int) else $error("interrupt without done");
  property p_swap; acc && opByte0 == 8'h0f && opByte1[7:3] == 5'h19 |=> swapOut == $past(swapExp) ##3 done; endproperty
  a_swap: assert property (p_swap) else $error("byte swap");
  property p_miss; acc && memMiss && !twoRegEa && opByte0 == 8'h00 && opByte1[7:6] != 2'b11 |=> latency == missLat; endproperty
  a_miss: assert property (p_miss) else $error("miss extra");
endmodule
bind xabd_decode_timing xabd_decode_timing_props #(.CLK_RATIO3X(CLK_RATIO3X)) u_props (
  .clk(clk), .resetn(resetn), .start(start), .busy(busy), .done(done), .opByte0(opByte0),
  .opByte1(opByte1), .protMode(protMode), .memMiss(memMiss), .twoRegEa(twoRegEa),
  .boundOut(boundOut), .mulExtra(mulExtra), .swapIn(swapIn), .opClass(opClass),
  .latency(latency), .flagWrMask(flagWrMask), .flagClrMask(flagClrMask),
  .flagUndefMask(flagUndefMask), .raiseInt(raiseInt), .intVector(intVector), .swapOut(swapOut));

// ---- testbench/xabd_decode_timing_tb.sv ----
// testbench: directed decode and timing scenarios
`timescale 1ns/10ps
module xabd_decode_timing_tb;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg start = 1'b0;
  reg [7:0] b0 = 8'h00, b1 = 8'h00, b2 = 8'h00;
  reg [3:0] md = 4'h0, mulExtra = 4'h0;
  reg [31:0] swapIn = 32'h00000000;
  wire busy, done, illegal, raiseInt;
  wire [3:0] opClass;
  wire [2:0] regNum;
  wire [5:0] clrMask;
  wire [7:0] intVector;
  wire [31:0] swapOut;
  integer mismatches = 0, comparisons = 0, cyc = 0;
  reg gotInt = 1'b0;
  always #50 clk = ~clk;
  xabd_decode_timing dut (.clk(clk), .resetn(resetn), .start(start), .opByte0(b0),
    .opByte1(b1), .opByte2(b2), .protMode(md[3]), .memMiss(md[2]), .twoRegEa(md[1]),
    .boundOut(md[0]), .mulExtra(mulExtra), .swapIn(swapIn), .busy(busy), .done(done),
    .opClass(opClass), .latency(), .flagWrMask(), .flagClrMask(clrMask), .flagUndefMask(),
    .illegal(illegal), .raiseInt(raiseInt), .intVector(intVector), .regNum(regNum),
    .swapOut(swapOut));
  // ----
  // shared tasks
  // ----
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // counts cycles from the accepting edge to done; bounded so a stuck op cannot hang
  task tc(input [7:0] a, b, c, input [3:0] m, x, input [4:0] eCyc, input [3:0] eCls);
    begin
      @(posedge clk); #1;
      b0 = a; b1 = b; b2 = c; md = m; mulExtra = x; start = 1'b1;
      @(posedge clk); #1;
      start = 1'b0; cyc = 1;
      while (done !== 1'b1 && cyc < 40) begin
        @(posedge clk); #1;
        cyc = cyc + 1;
      end
      gotInt = raiseInt;
      chk(cyc, eCyc);
      chk(opClass, eCls);
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_adjust;
    begin
      tc(8'h37, 8'h00, 8'h00, 4'h8, 4'h0, 5'h07, 4'h1);
      tc(8'h3f, 8'h00, 8'h00, 4'h0, 4'h0, 5'h07, 4'h1);
      tc(8'hd5, 8'h0a, 8'h00, 4'h8, 4'h0, 5'h07, 4'h1);
      tc(8'hd4, 8'h0a, 8'h00, 4'h0, 4'h0, 5'h0d, 4'h2);
      tc(8'hd4, 8'h0a, 8'h00, 4'h8, 4'h8, 5'h15, 4'h2);
      tc(8'hd4, 8'h0a, 8'h00, 4'h0, 4'hf, 5'h15, 4'h2);
    end
  endtask
  task t_alu;
    begin
      tc(8'h00, 8'hc0, 8'h00, 4'h0, 4'h0, 5'h01, 4'h4);
      tc(8'h80, 8'hc0, 8'h00, 4'h8, 4'h0, 5'h01, 4'h4);
      tc(8'h80, 8'hd0, 8'h00, 4'h0, 4'h0, 5'h01, 4'h3);
      tc(8'h14, 8'h00, 8'h00, 4'h0, 4'h0, 5'h01, 4'h3);
      tc(8'h03, 8'hc0, 8'h00, 4'h0, 4'h0, 5'h01, 4'h4);
      tc(8'h25, 8'h00, 8'h00, 4'h4, 4'h0, 5'h01, 4'h5);
      tc(8'h06, 8'h00, 8'h00, 4'h0, 4'h0, 5'h01, 4'h0);
      chk(illegal, 1'b1);
      tc(8'h20, 8'hc0, 8'h00, 4'h0, 4'h0, 5'h01, 4'h5);
      chk(clrMask, 6'h21);
      tc(8'h80, 8'he0, 8'h00, 4'h0, 4'h0, 5'h01, 4'h5);
      tc(8'h00, 8'h05, 8'h00, 4'h4, 4'h0, 5'h03, 4'h4);
      tc(8'h02, 8'h04, 8'h00, 4'h2, 4'h0, 5'h02, 4'h4);
    end
  endtask
  task t_sys;
    begin
      tc(8'h63, 8'hc0, 8'h00, 4'h8, 4'h0, 5'h09, 4'h6);
      tc(8'h63, 8'hc0, 8'h00, 4'h0, 4'h0, 5'h01, 4'h0);
      chk(illegal, 1'b1);
      tc(8'h62, 8'h00, 8'h00, 4'h0, 4'h0, 5'h0b, 4'h7);
      tc(8'h62, 8'h00, 8'h00, 4'h1, 4'h0, 5'h14, 4'h7);
      chk({gotInt, intVector}, 9'h105);
    end
  endtask
  task t_bits;
    begin
      tc(8'h0f, 8'hbc, 8'hc0, 4'h0, 4'h0, 5'h03, 4'h8);
      tc(8'h0f, 8'hbd, 8'hc0, 4'h8, 4'h0, 5'h03, 4'h8);
      tc(8'h0f, 8'hba, 8'he0, 4'h0, 4'h0, 5'h02, 4'ha);
      tc(8'h0f, 8'ha3, 8'hc0, 4'h0, 4'h0, 5'h05, 4'ha);
      tc(8'h0f, 8'ha3, 8'h00, 4'h0, 4'h0, 5'h06, 4'ha);
      tc(8'h0f, 8'hba, 8'hf8, 4'h0, 4'h0, 5'h03, 4'hb);
      tc(8'h0f, 8'hbb, 8'h00, 4'h0, 4'h0, 5'h06, 4'hb);
      swapIn = 32'h11223344;
      tc(8'h0f, 8'hcb, 8'h00, 4'h0, 4'h0, 5'h04, 4'h9);
      chk(swapOut, 32'h44332211);
      chk(regNum, 3'h3);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
    t_adjust;
    t_alu;
    t_sys;
    t_bits;
    results;
  end
  initial begin
    #(3000 * 100);
    mismatches = mismatches + 1;
    results;
  end
endmodule
